// [dic_dram_ctrl.sv]
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dic_dram_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// area 2 access request
	input wire logic acc_req,
	input wire dic_pkg::dic_req_t acc_info,
	output logic acc_done,
	output logic area2_dram,
	// memory pins
	output dic_pkg::dic_pins_t pins
);
	import dic_pkg::*;

	dic_ctrl_t ctl_q;
	dic_state_t st_q;
	logic ph_q;
	logic [1:0] col_cnt_q;
	logic open_q;
	logic wr_q;
	logic [11:0] row_q;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_wr;
	logic [1:0] col_last;
	logic hold_ok;
	logic hit;
	logic ras_low;
	logic [31:0] stat;

	assign do_wr = !awready && !wready && !bvalid;
	// column cycle length in states, minus one
	assign col_last = ctl_q.column_cycle_length_select ?
		2'(DIC_COL_LONG - 1) : 2'(DIC_COL_SHORT - 1);
	// down mode only counts while burst is on
	assign hold_ok = ctl_q.page_burst_enable &&
		ctl_q.row_strobe_hold_low_mode;
	assign hit = open_q && ctl_q.page_burst_enable &&
		acc_info.row == row_q;
	assign stat = {16'h0000, st_q, open_q, 1'b0, row_q};

	// axi write address and data slots
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
			wready <= 1'b1;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	// axi write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= DIC_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp <= (aw_addr_q == DIC_CTRL_OFS) ? DIC_OKAY : DIC_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// control register, reserved bits kept as storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q <= DIC_CTRL_RST;
		end else if (do_wr && aw_addr_q == DIC_CTRL_OFS) begin
			if (w_strb_q[0]) begin
				ctl_q[7:0] <= w_data_q[7:0];
			end
			if (w_strb_q[1]) begin
				ctl_q[15:8] <= w_data_q[15:8];
			end
		end
	end

	// axi read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= DIC_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= DIC_OKAY;
			unique case (araddr)
				DIC_CTRL_OFS: rdata <= {16'h0000, ctl_q};
				DIC_STAT_OFS: rdata <= stat;
				default: begin
					rdata <= 32'h0;
					rresp <= DIC_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// half-state divider: a bus state is two clocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_q <= 1'b0;
		end else begin
			ph_q <= !ph_q;
		end
	end

	// access sequencer, moves only at state boundaries
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= DIC_IDLE;
			col_cnt_q <= 2'h0;
			wr_q <= 1'b0;
			row_q <= 12'h000;
		end else if (ph_q) begin
			unique case (st_q)
				DIC_IDLE: begin
					if (acc_req && ctl_q.area2_dram_select) begin
						wr_q <= acc_info.write;
						row_q <= acc_info.row;
						col_cnt_q <= 2'h0;
						if (hit) begin
							st_q <= DIC_COL;
						end else if (open_q) begin
							st_q <= DIC_PRE;
						end else begin
							st_q <= DIC_ROW;
						end
					end
				end
				DIC_ROW: st_q <= DIC_COL;
				DIC_COL: begin
					if (col_cnt_q == col_last) begin
						st_q <= DIC_IDLE;
					end else begin
						col_cnt_q <= col_cnt_q + 2'h1;
					end
				end
				DIC_PRE: st_q <= DIC_ROW;
			endcase
		end
	end

	// open row tracking for page mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			open_q <= 1'b0;
		end else if (st_q == DIC_IDLE && !hold_ok) begin
			open_q <= 1'b0;
		end else if (ph_q && st_q == DIC_COL && col_cnt_q == col_last) begin
			open_q <= hold_ok;
		end else if (st_q == DIC_PRE) begin
			open_q <= 1'b0;
		end
	end

	always_comb begin
		ras_low = 1'b0;
		unique case (st_q)
			// early edge at state start, else second half
			DIC_ROW: ras_low = ph_q || ctl_q.row_strobe_edge_select;
			DIC_COL: ras_low = 1'b1;
			DIC_IDLE: ras_low = open_q;
			DIC_PRE: ras_low = 1'b0;
		endcase
	end

	// registered pins and status outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins <= '{ras_n: 1'b1, cas_n: 1'b1, rd_n: 1'b1,
				we_n: 1'b1, col_sel: 1'b0};
			acc_done <= 1'b0;
			area2_dram <= 1'b0;
		end else begin
			pins.ras_n <= !ras_low;
			pins.cas_n <= !(st_q == DIC_COL && (ph_q || col_cnt_q != 2'h0));
			// read strobe doubles as output enable for edo parts
			pins.rd_n <= !(st_q == DIC_COL && !wr_q);
			pins.we_n <= !(st_q == DIC_COL && wr_q);
			pins.col_sel <= st_q == DIC_COL;
			acc_done <= ph_q && st_q == DIC_COL && col_cnt_q == col_last;
			area2_dram <= ctl_q.area2_dram_select;
		end
	end

	// cycles spent in the column cycle, for checking only
	logic [2:0] col_cyc_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || st_q != DIC_COL) begin
			col_cyc_q <= 3'h0;
		end else begin
			col_cyc_q <= col_cyc_q + 3'h1;
		end
	end

	ras_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == DIC_ROW && !ph_q) |=>
		pins.ras_n == !$past(ctl_q.row_strobe_edge_select))
		else $error("row strobe edge does not follow edge select");
	col_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == DIC_COL && ph_q && col_cnt_q == col_last) |->
		col_cyc_q == (ctl_q.column_cycle_length_select ?
		3'(2 * DIC_COL_LONG - 1) : 3'(2 * DIC_COL_SHORT - 1)))
		else $error("column cycle has wrong number of states");
	area_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == DIC_IDLE && !ctl_q.area2_dram_select) |=>
		st_q == DIC_IDLE && area2_dram == $past(ctl_q.area2_dram_select))
		else $error("access started while area 2 is normal space");
	no_burst_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == DIC_IDLE && ph_q && !ctl_q.page_burst_enable) |=>
		st_q != DIC_COL)
		else $error("page access taken with burst disabled");
	ras_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == DIC_IDLE && !ctl_q.page_burst_enable) [*2] |=>
		pins.ras_n)
		else $error("row strobe held low with burst disabled");
	ctl_reset_a: assert property (@(posedge aclk)
		!aresetn |=> ctl_q == DIC_CTRL_RST && !area2_dram)
		else $error("control register not cleared by reset");
	late_ras_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(st_q == DIC_ROW && ph_q) |=> !pins.ras_n)
		else $error("row strobe high in second half of row cycle");
	dram_take_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(st_q == DIC_IDLE && ph_q && acc_req &&
		ctl_q.area2_dram_select) |=> st_q != DIC_IDLE)
		else $error("request in dram space not started");
	fast_page_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(st_q == DIC_IDLE && ph_q && acc_req && hit &&
		ctl_q.area2_dram_select) |=> st_q == DIC_COL)
		else $error("page hit did not skip the row cycle");
	hold_drop_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(st_q == DIC_IDLE && !hold_ok) |=> !open_q)
		else $error("row kept open without burst hold-low mode");
	pin_reset_a: assert property (@(posedge aclk)
		!aresetn |=> pins.ras_n && pins.cas_n && !pins.col_sel && !acc_done)
		else $error("pins not idle after reset");

	// bus handshake checks
	b_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvalid && !bready) |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");
	r_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(rvalid && !rready) |=> rvalid && $stable(rdata))
		else $error("read data dropped before rready");

	page_hit_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st_q == DIC_IDLE && ph_q && acc_req && hit &&
		ctl_q.area2_dram_select);
	long_col_c: cover property (@(posedge aclk) disable iff (!aresetn)
		acc_done && ctl_q.column_cycle_length_select);
	precharge_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st_q == DIC_PRE);
	hold_low_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st_q == DIC_IDLE && open_q && !pins.ras_n);
	early_ras_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st_q == DIC_ROW && ctl_q.row_strobe_edge_select);
endmodule
`default_nettype wire

// [dic_dram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dic_dram_model (
	// clock
	input wire logic aclk,
	// memory pins
	input wire dic_pkg::dic_pins_t pins,
	// measured timing of the last access, and a running count of cycles with output enable and column strobe both low
	output int col_len,
	output int ras_lead,
	output int oe_cycles
);
	import dic_pkg::*;
	int cc = 0;
	int rc = 0;
	logic pc = 1'b0;
	// read strobe wired to the memory output enable
	wire logic mem_oe_n = pins.rd_n;
	initial begin
		col_len = 0;
		ras_lead = 0;
		oe_cycles = 0;
	end
	always @(posedge aclk) begin
		if (pins.col_sel) cc <= cc + 1;
		else if (cc != 0) begin
			col_len <= cc;
			cc <= 0;
		end
		if (pins.ras_n) rc <= 0;
		else if (!pins.col_sel) rc <= rc + 1;
		if (pins.col_sel && !pc) ras_lead <= rc;
		pc <= pins.col_sel;
		// memory drives data only while selected and output-enabled
		if (!mem_oe_n && !pins.cas_n) oe_cycles <= oe_cycles + 1;
	end
endmodule
`default_nettype wire

// [dic_pkg.sv]
// Overview of operation
// - bit 14 set asserts row strobe at row cycle start, else mid-state.
// - bit 12 makes the column cycle three states, otherwise two states.
// - bit 8 set makes area 2 DRAM space, clear leaves normal space.
// - bit 7 set allows fast page burst accesses, clear forces full ones.
// - hold-low mode applies only with burst on; otherwise strobe rises.
`default_nettype none
package dic_pkg;
	localparam logic [3:0] DIC_CTRL_OFS = 4'h0;
	localparam logic [3:0] DIC_STAT_OFS = 4'h4;
	localparam logic [15:0] DIC_CTRL_RST = 16'h0000;
	localparam int DIC_COL_SHORT = 2;
	localparam int DIC_COL_LONG = 3;
	localparam logic [1:0] DIC_OKAY = 2'h0;
	localparam logic [1:0] DIC_SLVERR = 2'h2;

	typedef struct packed {
		logic res15;
		logic row_strobe_edge_select;
		logic res13;
		logic column_cycle_length_select;
		logic [2:0] res11_9;
		logic area2_dram_select;
		logic page_burst_enable;
		logic row_strobe_hold_low_mode;
		logic [5:0] low_bits;
	} dic_ctrl_t;

	typedef enum logic [1:0] {
		DIC_IDLE = 2'h0,
		DIC_ROW = 2'h1,
		DIC_COL = 2'h3,
		DIC_PRE = 2'h2
	} dic_state_t;

	typedef struct packed {
		logic write;
		logic [11:0] row;
	} dic_req_t;

	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic rd_n;
		logic we_n;
		logic col_sel;
	} dic_pins_t;
endpackage
`default_nettype wire

// [tb_dram_interface_control_bits.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dram_interface_control_bits;
	import dic_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'h3;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, acc_done, area2_dram;
	logic [31:0] wdata = '0, rdata;
	logic [1:0] bresp, rresp, r;
	logic acc_req = 0, got;
	dic_req_t acc_info = '0;
	dic_pins_t pins;
	logic [31:0] d;
	logic [15:0] v;
	int col_len, ras_lead, oe_cycles, num_errors = 0, total_checks = 0;
	int o;
	initial forever #10 aclk = ~aclk;
	dic_dram_ctrl i_dic_dram_ctrl (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .acc_req(acc_req), .acc_info(acc_info),
		.acc_done(acc_done), .area2_dram(area2_dram), .pins(pins));
	dic_dram_model i_dic_dram_model (.aclk(aclk), .pins(pins),
		.col_len(col_len), .ras_lead(ras_lead), .oe_cycles(oe_cycles));
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] x);
		int n;
		awaddr <= a;
		wdata <= {16'h0000, x};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin
				r = bresp;
				bready <= 0;
				break;
			end
		end
		if (n == 50) begin
			num_errors++;
			close_out();
		end
	endtask
	task automatic rd(input logic [3:0] a);
		int n;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 0;
				break;
			end
		end
		if (n == 50) begin
			num_errors++;
			close_out();
		end
	endtask
	// request held until the done pulse or for at most 40 clocks, dropped at the edge that sees it
	task automatic acc(input logic [11:0] row);
		int n;
		got = 0;
		acc_info <= '{write: row[0], row: row};
		acc_req <= 1;
		for (n = 0; n < 40 && !got; n++) begin
			@(posedge aclk);
			if (acc_done === 1'b1) got = 1;
		end
		acc_req <= 0;
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(DIC_CTRL_OFS);
		chk("ctrl reset", d, 32'h00000000);
		chk("area2 reset", area2_dram, 1'b0);
		wr(DIC_CTRL_OFS, 16'h5027);
		rd(DIC_CTRL_OFS);
		chk("ctrl readback", d, 32'h00005027);
		wr(4'h8, 16'h1234);
		chk("unmapped write", r, DIC_SLVERR);
		rd(4'h8);
		chk("unmapped read", r, DIC_SLVERR);
		wr(DIC_CTRL_OFS, 16'h0000);
		acc(12'h005);
		chk("normal space", got, 1'b0);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			v = 16'h0100 | (i[0] ? 16'h1000 : 16'h0000);
			v = v | (i[1] ? 16'h4000 : 16'h0000);
			wr(DIC_CTRL_OFS, v);
			o = oe_cycles;
			acc(12'h010 + 12'(i));
			chk("dram done", got, 1'b1);
			chk("col len", 32'(col_len),
				32'(2 * (i[0] ? DIC_COL_LONG : DIC_COL_SHORT)));
			chk("ras lead", 32'(ras_lead), i[1] ? 32'd2 : 32'd1);
			chk("oe overlap", 32'(oe_cycles - o),
				i[0] ? 32'd0 : 32'(2 * DIC_COL_SHORT - 1));
		end
		chk("area2 dram", area2_dram, 1'b1);
		$display("test timing done");
		wr(DIC_CTRL_OFS, 16'h01C0);
		acc(12'h020);
		acc(12'h020);
		chk("ras held", pins.ras_n, 1'b0);
		chk("page hit", ras_lead > 2, 1'b1);
		rd(DIC_STAT_OFS);
		chk("open row status", d, 32'h00002020);
		wr(DIC_CTRL_OFS, 16'h0140);
		acc(12'h020);
		chk("ras up", pins.ras_n, 1'b1);
		chk("full access", 32'(ras_lead), 32'd1);
		$display("test burst done");
		aresetn <= 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(DIC_CTRL_OFS);
		chk("ctrl after reset", d, 32'h00000000);
		chk("area2 after reset", area2_dram, 1'b0);
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
